// >>> hdl/hbridge_gate_control_fault.sv
// gate control and protection logic of a two-output bridge driver
// assumes all inputs synchronous to clk_i; floating pins arrive
// as separate float flags from the pad sensing
//
// Summary of operation
// R1: enabled, not disabled: outputs follow commands, flag high
// R2: any disable active: outputs Z, flag low
// R3: enable low or floating: sleep, Z, flag high
// R4: floating command high; floating disable disables
// R5: undervoltage: Z, flag low, auto recovery
// R6: short or overtemp latches outputs Z, flag low
// R7: latch cleared only by disable, enable or supply toggle
// R8: disable release edge clears short latch
// R9: after clear, outputs follow inputs if temperature normal
// R10: current limit: outputs Z for fixed off-time
// R11: above 160 C select reduced limit threshold
// R12: above 175 C overtemperature latches off
// R13: overtemp clear needs temperature below hysteresis point
// R14: power cycle clears latched fault
// R15: host limits hot operation below 30 seconds
// R16: polarity invert makes commands active low
// R17: blanking timer restarts on each output transition
// R18: off-time and blanking timed by restartable counters
`timescale 1ns/100ps
module hbridge_gate_control_fault #(
  parameter int unsigned OFF_CYCLES = hbridge_pkg::LIMIT_OFF_CYCLES,
  parameter int unsigned BLANK_CYCLES = hbridge_pkg::SHORT_BLANK_CYCLES
) (
  input wire logic clk_i, // 50 MHz clock
  input wire logic rst_n_i, // async reset, low
  input wire logic enable_i, // sleep enable, high runs
  input wire logic enable_float_i, // enable pin floating
  input wire logic disable_hi_active_i, // disable, active high
  input wire logic disable_hi_float_i, // that pin floating
  input wire logic disable_lo_active_n_i, // disable, active low
  input wire logic disable_lo_float_i, // that pin floating
  input wire logic drive_cmd_a_i, // command for output a
  input wire logic drive_cmd_a_float_i, // command a floating
  input wire logic drive_cmd_b_i, // command for output b
  input wire logic drive_cmd_b_float_i, // command b floating
  input wire logic polarity_invert_i, // commands active low
  input wire logic main_supply_ok_i, // supply above lockout
  input wire logic over_limit_normal_i, // current above normal limit
  input wire logic over_limit_reduced_i, // current above reduced limit
  input wire logic temp_above_160_i, // junction above 160 C
  input wire logic thermal_limit_detect_i, // junction above 175 C
  input wire logic temp_below_hyst_i, // below shutdown minus hyst
  input wire logic short_detect_i, // raw short-circuit sense
  output logic [1:0] bridge_out_a_o, // drive code a
  output logic [1:0] bridge_out_b_o, // drive code b
  output logic fault_flag_n_o, // fault flag, low = fault
  output logic fault_flag_n_oe_o, // open drain enable
  output logic current_limit_reduced_o // reduced threshold in use
);
  ////////////////////////////////////////////////////////////////////
  // two copies of one retriggerable timer: the limit off-time and the
  // short blanking window; each loads its length on start and reports
  // busy until it has counted down to zero
  hbridge_timer_if off_if ();
  hbridge_timer_if blank_if ();
  hbridge_interval_timer u_off (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tmr(off_if.timer)
  );
  hbridge_interval_timer u_blank (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tmr(blank_if.timer)
  );
  ////////////////////////////////////////////////////////////////////
  logic en_eff;
  logic dis_eff;
  logic cmd_a;
  logic cmd_b;
  logic over_limit;
  logic supply_q;
  logic dis_q;
  logic en_q;
  logic latch_short;
  logic latch_temp;
  logic clear_edge;
  logic temp_hold;
  logic [1:0] next_a;
  logic [1:0] next_b;
  hbridge_pkg::mode_e mode;

  // pin qualification: a floating pin takes its default sense, so the
  // enable defaults to sleep and either disable defaults to disabled
  always_comb begin
    en_eff = enable_i && !enable_float_i; // R3
    dis_eff = disable_hi_active_i || disable_hi_float_i ||
              !disable_lo_active_n_i || disable_lo_float_i; // R4
    // a floating command reads high before inversion
    cmd_a = (drive_cmd_a_i || drive_cmd_a_float_i) ^
            polarity_invert_i; // R4 R16
    cmd_b = (drive_cmd_b_i || drive_cmd_b_float_i) ^
            polarity_invert_i; // R16
    over_limit = temp_above_160_i ? over_limit_reduced_i
                                  : over_limit_normal_i; // R11
  end

  // a disable release edge or a re-enable clears a latch
  assign clear_edge = (dis_q && !dis_eff) || (!en_q && en_eff); // R7 R8
  // a supply return counts as a power cycle
  assign temp_hold = !temp_below_hyst_i; // R13

  // previous-cycle copies for the clear edges; reset values are the disabled,
  // asleep and no-supply levels, so leaving reset with supply ok shows a supply return

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dis_q <= 1'b1;
      en_q <= 1'b0;
      supply_q <= 1'b0;
    end else begin
      dis_q <= dis_eff;
      en_q <= en_eff;
      supply_q <= main_supply_ok_i;
    end
  end

  // short latch: detection is ignored while blanking runs
  // detection needs a driven output; a released bridge carries no
  // current, so a sense pulse then is not a fault
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_short <= 1'b0; // R14
    end else if (short_detect_i && !blank_if.busy &&
                 mode == hbridge_pkg::ST_RUN &&
                 bridge_out_a_o != hbridge_pkg::DRV_Z) begin
      latch_short <= 1'b1; // R6
    end else if (clear_edge || (main_supply_ok_i && !supply_q)) begin
      latch_short <= 1'b0; // R7 R8 R14
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_temp <= 1'b0; // R14
    // sets only while awake; release waits for the hysteresis point
    end else if (thermal_limit_detect_i && en_eff) begin
      latch_temp <= 1'b1; // R12 R6
    end else if ((clear_edge || (main_supply_ok_i && !supply_q)) &&
                 !temp_hold) begin
      latch_temp <= 1'b0; // R13 R7
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sleep wins over a latch; waking is an enable edge, which clears
  // the latch one cycle later
  always_comb begin
    if (!en_eff) begin
      mode = hbridge_pkg::ST_SLEEP;
    end else if (latch_short || latch_temp) begin
      mode = hbridge_pkg::ST_LATCHED;
    end else begin
      mode = hbridge_pkg::ST_RUN;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // current limit off-time, retriggered only when outputs are on
  // a limit event during the off-time does not extend it
  assign off_if.length = 16'(OFF_CYCLES);
  assign off_if.start = over_limit && !off_if.busy &&
                        mode == hbridge_pkg::ST_RUN && !dis_eff &&
                        main_supply_ok_i; // R10 R18
  assign blank_if.length = 16'(BLANK_CYCLES);
  assign blank_if.start = (next_a != bridge_out_a_o) ||
                          (next_b != bridge_out_b_o); // R17 R18

  // output decode; the off-time also masks the cycle in which it starts
  // so the bridge goes off at the same edge that loads the timer
  always_comb begin
    next_a = hbridge_pkg::DRV_Z;
    next_b = hbridge_pkg::DRV_Z;
    unique case (mode)
      hbridge_pkg::ST_SLEEP: begin
        next_a = hbridge_pkg::DRV_Z; // R3
      end
      hbridge_pkg::ST_LATCHED: begin
        next_a = hbridge_pkg::DRV_Z; // R6
      end
      hbridge_pkg::ST_RUN: begin
        if (!dis_eff && main_supply_ok_i && !off_if.busy &&
            !off_if.start) begin
          next_a = cmd_a ? hbridge_pkg::DRV_HIGH
                         : hbridge_pkg::DRV_LOW; // R1 R9
          next_b = cmd_b ? hbridge_pkg::DRV_HIGH
                         : hbridge_pkg::DRV_LOW; // R1 R9
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bridge_out_a_o <= hbridge_pkg::DRV_Z;
      bridge_out_b_o <= hbridge_pkg::DRV_Z;
    end else begin
      bridge_out_a_o <= next_a; // R2 R5 R10
      bridge_out_b_o <= next_b;
    end
  end

  // flag low on disable, lockout or latch; never in sleep
  // the flag pin is open drain: its level is high in reset and low from the first clock
  // after it, and only the enable decides whether the pin is pulled
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_flag_n_o <= 1'b1;
      fault_flag_n_oe_o <= 1'b0;
      current_limit_reduced_o <= 1'b0;
    end else begin
      fault_flag_n_o <= 1'b0;
      fault_flag_n_oe_o <= en_eff && (dis_eff || !main_supply_ok_i ||
                           latch_short || latch_temp); // R2 R3 R5 R6
      current_limit_reduced_o <= temp_above_160_i; // R11
    end
  end
endmodule

// >>> hdl/hbridge_interval_timer.sv
// retriggerable down counter; busy while counting
// assumes start is a one-cycle pulse in the clk_i domain
`timescale 1ns/100ps
module hbridge_interval_timer (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  hbridge_timer_if.timer tmr // start and status
);
  logic [15:0] count;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= 16'h0000;
    end else if (tmr.start) begin
      count <= tmr.length; // R18
    end else if (count != 16'h0000) begin
      count <= count - 16'h0001;
    end
  end
  assign tmr.busy = (count != 16'h0000);
endmodule

// >>> hdl/hbridge_pkg.sv
// constants for the bridge gate control and fault logic
// assumes a 50 MHz system clock
package hbridge_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned LIMIT_OFF_TIME_NS = 20000;
  localparam int unsigned LIMIT_OFF_CYCLES =
    (LIMIT_OFF_TIME_NS / 1000) * (CLK_HZ / 1000000);
  localparam int unsigned SHORT_BLANK_TIME_NS = 2000;
  localparam int unsigned SHORT_BLANK_CYCLES =
    (SHORT_BLANK_TIME_NS / 1000) * (CLK_HZ / 1000000);
  localparam int unsigned TIMER_W = 16;
  // output drive codes
  localparam logic [1:0] DRV_Z = 2'h0;
  localparam logic [1:0] DRV_LOW = 2'h1;
  localparam logic [1:0] DRV_HIGH = 2'h3;
  typedef enum logic [1:0] {ST_SLEEP, ST_RUN, ST_LATCHED} mode_e;
endpackage

// >>> hdl/hbridge_timer_if.sv
// handshake between bridge control and its interval timer
// assumes one clock domain
`timescale 1ns/100ps
interface hbridge_timer_if;
  logic start;
  logic [15:0] length;
  logic busy;
  modport ctrl (output start, output length, input busy);
  modport timer (input start, input length, output busy);
endinterface

// >>> tb/hbridge_host_model.sv
// host controller model that drives the bridge control pins
// assumes the bench calls its tasks from a single process
`timescale 1ns/100ps
module hbridge_host_model (
  input wire logic clk_i, // system clock
  output logic [10:0] pins_o // en,enf,dhi,dhf,dlo_n,dlf,a,af,b,bf,inv
);
  initial pins_o = 11'h000;
  // levels change after a falling edge, well clear of sampling
  task automatic put(input logic [10:0] v);
    @(negedge clk_i);
    pins_o = v;
  endtask
  // a latched fault clears on a disable pulse, a re-enable or a supply return; this task pulses the disable
  task automatic unlatch();
    put(pins_o & ~11'h040);
    put(pins_o | 11'h040);
  endtask
endmodule

// >>> tb/hbridge_monitor.sv
// concurrent checks on the bridge control ports
// assumes bind into the control block, one clock domain
`timescale 1ns/100ps
module hbridge_monitor (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic enable_i, // enable
  input wire logic enable_float_i, // enable floating
  input wire logic disable_hi_active_i, // disable high
  input wire logic disable_hi_float_i, // floating
  input wire logic disable_lo_active_n_i, // disable low
  input wire logic disable_lo_float_i, // floating
  input wire logic drive_cmd_a_i, // command a
  input wire logic drive_cmd_a_float_i, // floating
  input wire logic drive_cmd_b_i, // command b
  input wire logic drive_cmd_b_float_i, // floating
  input wire logic polarity_invert_i, // invert
  input wire logic main_supply_ok_i, // supply ok
  input wire logic over_limit_normal_i, // normal limit
  input wire logic over_limit_reduced_i, // reduced limit
  input wire logic temp_above_160_i, // hot
  input wire logic thermal_limit_detect_i, // overtemp
  input wire logic [1:0] bridge_out_a_o, // out a
  input wire logic [1:0] bridge_out_b_o, // out b
  input wire logic fault_flag_n_oe_o, // flag pull
  input wire logic current_limit_reduced_o // reduced in use
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic en, dis, run, z, lim;
  logic [1:0] ea, eb;
  assign en = enable_i & ~enable_float_i;
  assign dis = disable_hi_active_i | disable_hi_float_i
    | ~disable_lo_active_n_i | disable_lo_float_i;
  assign run = en & ~dis & main_supply_ok_i;
  assign z = bridge_out_a_o == hbridge_pkg::DRV_Z
    && bridge_out_b_o == hbridge_pkg::DRV_Z;
  // limit compare follows the temperature-selected threshold
  assign lim = temp_above_160_i ? over_limit_reduced_i : over_limit_normal_i;
  assign ea = ((drive_cmd_a_i | drive_cmd_a_float_i) ^ polarity_invert_i)
    ? hbridge_pkg::DRV_HIGH : hbridge_pkg::DRV_LOW;
  assign eb = ((drive_cmd_b_i | drive_cmd_b_float_i) ^ polarity_invert_i)
    ? hbridge_pkg::DRV_HIGH : hbridge_pkg::DRV_LOW;
  sleep_off_a: assert property (!en |=> z && !fault_flag_n_oe_o)
    else $error("sleep state wrong");
  disable_off_a: assert property (
    en && dis |=> z && fault_flag_n_oe_o)
    else $error("disable state wrong");
  uvlo_off_a: assert property (
    en && !main_supply_ok_i |=> z && fault_flag_n_oe_o)
    else $error("undervoltage state wrong");
  drive_a_a: assert property (
    bridge_out_a_o != hbridge_pkg::DRV_Z |-> bridge_out_a_o == $past(ea))
    else $error("output a level wrong");
  drive_b_a: assert property (
    bridge_out_b_o != hbridge_pkg::DRV_Z |-> bridge_out_b_o == $past(eb))
    else $error("output b level wrong");
  flag_run_a: assert property (
    bridge_out_a_o != hbridge_pkg::DRV_Z |-> !fault_flag_n_oe_o)
    else $error("flag low while driving");
  overtemp_off_a: assert property (
    run && thermal_limit_detect_i |-> ##[1:2] z && fault_flag_n_oe_o)
    else $error("overtemperature not latched");
  limit_off_a: assert property (run && $rose(lim) |-> ##[1:2] z)
    else $error("current limit did not switch off");
  reduced_sel_a: assert property (
    1'b1 |=> current_limit_reduced_o == $past(temp_above_160_i))
    else $error("reduced limit flag wrong");
endmodule
bind hbridge_gate_control_fault hbridge_monitor mon (.*);

// >>> tb/tb.sv
// self-checking bench for the bridge gate control and fault block
// assumes short timer parameters so the off-time stays brief
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0, rst_n = 1'b0, ok = 1'b1;
  logic t160 = 1'b0, hyst = 1'b1;
  // senses: 0 over normal, 1 over reduced, 2 overtemp, 3 short
  logic [3:0] sns = 4'h0;
  logic [10:0] p;
  logic [1:0] oa, ob;
  logic fl, oe, red;
  int error_cnt = 0;
  int cmp_count = 0;
  // pins in [15:5], expected {out_a, out_b, flag pull} in [4:0]
  logic [15:0] rows [15] = '{16'h8A1A, 16'h888E, 16'h880A, 16'h8A9E,
    16'hA801, 16'h8001, 16'h891A, 16'h884E, 16'h9801, 16'h8C01,
    16'h0A00, 16'hCA00, 16'h8A2E, 16'h883E, 16'h2800};
  always #10 clk = ~clk;
  hbridge_host_model host (.clk_i(clk), .pins_o(p));
  hbridge_gate_control_fault #(.OFF_CYCLES(8), .BLANK_CYCLES(4)) dut (
    .clk_i(clk), .rst_n_i(rst_n), .enable_i(p[10]), .enable_float_i(p[9]),
    .disable_hi_active_i(p[8]), .disable_hi_float_i(p[7]),
    .disable_lo_active_n_i(p[6]), .disable_lo_float_i(p[5]),
    .drive_cmd_a_i(p[4]), .drive_cmd_a_float_i(p[3]),
    .drive_cmd_b_i(p[2]), .drive_cmd_b_float_i(p[1]),
    .polarity_invert_i(p[0]), .main_supply_ok_i(ok),
    .over_limit_normal_i(sns[0]), .over_limit_reduced_i(sns[1]),
    .temp_above_160_i(t160), .thermal_limit_detect_i(sns[2]),
    .temp_below_hyst_i(hyst), .short_detect_i(sns[3]),
    .bridge_out_a_o(oa), .bridge_out_b_o(ob), .fault_flag_n_o(fl),
    .fault_flag_n_oe_o(oe), .current_limit_reduced_o(red));
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic cmp(input string n, input logic [4:0] e, input logic [4:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // one-cycle sense pulse, then time for latch and outputs to settle
  task automatic pulse(input int k);
    sns[k] = 1'b1;
    step(1);
    sns[k] = 1'b0;
    step(3);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    step(8);
    cmp("reset", 5'h00, {oa, ob, oe});
    rst_n = 1'b1;
    foreach (rows[i]) begin
      host.put(rows[i][15:5]);
      step(1);
      cmp("row", rows[i][4:0], {oa, ob, oe});
    end
    // a short right after a code change falls inside blanking
    host.put(11'h444);
    step(1);
    pulse(3);
    cmp("blank", 5'h0E, {oa, ob, oe});
    step(4);
    pulse(3);
    host.put(11'h450);
    step(2);
    cmp("short", 5'h01, {oa, ob, oe});
    host.unlatch();
    step(3);
    cmp("unlatch", 5'h1A, {oa, ob, oe});
    hyst = 1'b0;
    pulse(2);
    cmp("overtemp", 5'h01, {oa, ob, oe});
    host.unlatch();
    step(3);
    cmp("still hot", 5'h01, {oa, ob, oe});
    hyst = 1'b1;
    host.unlatch();
    step(3);
    cmp("cooled", 5'h1A, {oa, ob, oe});
    step(6);
    pulse(3);
    host.put(11'h050);
    host.put(11'h450);
    step(3);
    cmp("enable", 5'h1A, {oa, ob, oe});
    step(6);
    pulse(3);
    ok = 1'b0;
    step(2);
    cmp("uvlo", 5'h01, {oa, ob, oe});
    cmp("flag level", 5'h00, {4'h0, fl});
    ok = 1'b1;
    step(4);
    cmp("power", 5'h1A, {oa, ob, oe});
    pulse(0);
    cmp("off", 5'h00, {oa, ob, oe});
    step(3);
    cmp("off hold", 5'h00, {oa, ob, oe});
    step(6);
    cmp("resume", 5'h1A, {oa, ob, oe});
    pulse(1);
    cmp("cool lim", 5'h1A, {oa, ob, oe});
    t160 = 1'b1;
    pulse(1);
    cmp("hot lim", 5'h00, {oa, ob, oe});
    cmp("reduced", 5'h01, {4'h0, red});
    t160 = 1'b0;
    step(12);
    cmp("hot resume", 5'h1A, {oa, ob, oe});
    cmp("reduced off", 5'h00, {4'h0, red});
    conclude();
  end
endmodule
